// ==== logic/tfic_pkg.sv ====
/*
  Constants and types for the timer flag and input capture block.
  Assumes a byte-wide register map reached one register per 32-bit word.
*/
`default_nettype none
package tfic_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL    = 6'h12;
  localparam logic [5:0] IDX_FLAGS   = 6'h13;
  localparam logic [5:0] IDX_CAP1_HI = 6'h14;
  localparam logic [5:0] IDX_CAP1_LO = 6'h15;
  localparam logic [5:0] IDX_CMP1_HI = 6'h16;
  localparam logic [5:0] IDX_CMP1_LO = 6'h17;
  localparam logic [5:0] IDX_CNT_HI  = 6'h18;
  localparam logic [5:0] IDX_CNT_LO  = 6'h19;
  localparam logic [5:0] IDX_ALT_HI  = 6'h1A;
  localparam logic [5:0] IDX_ALT_LO  = 6'h1B;
  localparam logic [5:0] IDX_CAP2_HI = 6'h1C;
  localparam logic [5:0] IDX_CAP2_LO = 6'h1D;
  localparam logic [5:0] IDX_CMP2_HI = 6'h1E;
  localparam logic [5:0] IDX_CMP2_LO = 6'h1F;

  // ==========================================================
  // Flag vector positions, vector sits at register bits 7..3
  localparam int FLG_CAP1 = 4;
  localparam int FLG_CMP1 = 3;
  localparam int FLG_OVF  = 2;
  localparam int FLG_CAP2 = 1;
  localparam int FLG_CMP2 = 0;
  localparam int FLG_NUM  = 5;

  // Control register bit positions
  localparam int CTL_CAP_IE = 7;
  localparam int CTL_CMP_IE = 6;
  localparam int CTL_OVF_IE = 5;
  localparam int CTL_EDGE1  = 1;

  // ==========================================================
  // Counter values and prescaler
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  PRE_LAST  = 2'h3;

  // ==========================================================
  typedef logic [15:0] tfic_word_t;

  typedef struct packed {
    logic cap_irq_en;
    logic cmp_irq_en;
    logic ovf_irq_en;
    logic edge_sel;
  } tfic_ctrl_t;
endpackage
`default_nettype wire

// ==== logic/tfic_timer_flags.sv ====
/*
  Timer event flags, two input captures and the free-running counter,
  with an AHB-Lite register slave.
  Assumes capture pins and compare values are synchronous to CORE_CLK.
*/
// What this block does
// - Flags at bits 7..3 in fixed order
// - Flag clears: flag read (any access for overflow), then data low read
// - Chosen capture_in1 edge sets capture1_flag
// - Flags read then capture1 low clears
// - Compare1 match sets compare1_flag
// - Flags read then compare1 low clears
// - Counter wrap sets overflow_flag
// - Flags access then counter low clears overflow
// - Flag read or write arms overflow clear
// - Falling capture_in2 edge sets capture2_flag
// - Flags read then capture2 low clears
// - Compare2 match sets compare2_flag
// - Flags read then compare2 low clears
// - One enable gates both capture interrupts
// - capture1_value read-only, latches counter
// - capture2_value read-only, latches on falls
// - Captured value is prior count plus one
// - Capture resolution is four bus clocks
// - Every unlocked valid edge loads, flag regardless
// - High byte read blocks until low read
// - Low byte read never blocks transfer
// - Reset leaves capture registers unchanged
// - Edge select: one rising, zero falling
// - Counter advances every four bus clocks
// - Interrupt from any enabled set flag
// - Alternate counter read never clears overflow
`timescale 1ns/1ps
`default_nettype none
module tfic_timer_flags (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              CAPTURE_IN1,
  input  wire logic              CAPTURE_IN2,
  input  wire tfic_pkg::tfic_word_t COMPARE1_VALUE,
  input  wire tfic_pkg::tfic_word_t COMPARE2_VALUE,
  output tfic_pkg::tfic_word_t   COUNTER_VALUE,
  output logic                   TIMER_IRQ
);
  import tfic_pkg::*;

  function automatic logic hit(input logic [5:0] i, input logic [5:0] r);
    hit = (i == r);
  endfunction

  // ==========================================================
  // Bus address phase decode
  logic        acc;
  logic        rd_acc;
  logic        in_map;
  logic [5:0]  a_idx;
  logic        rd_flags;
  logic        touch_flags;
  logic        rd_cap1_hi;
  logic        rd_cap1_lo;
  logic        rd_cap2_hi;
  logic        rd_cap2_lo;
  logic        rd_cmp1_lo;
  logic        rd_cmp2_lo;
  logic        rd_cnt_lo;
  logic        rd_alt_lo;

  assign acc         = HSEL & HTRANS[1] & HREADY;
  assign in_map      = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
  assign a_idx       = HADDR[7:2];
  assign rd_acc      = acc & ~HWRITE;
  assign rd_flags    = rd_acc & in_map & hit(a_idx, IDX_FLAGS);
  assign touch_flags = acc & in_map & hit(a_idx, IDX_FLAGS);
  assign rd_cap1_hi  = rd_acc & in_map & hit(a_idx, IDX_CAP1_HI);
  assign rd_cap1_lo  = rd_acc & in_map & hit(a_idx, IDX_CAP1_LO);
  assign rd_cap2_hi  = rd_acc & in_map & hit(a_idx, IDX_CAP2_HI);
  assign rd_cap2_lo  = rd_acc & in_map & hit(a_idx, IDX_CAP2_LO);
  assign rd_cmp1_lo  = rd_acc & in_map & hit(a_idx, IDX_CMP1_LO);
  assign rd_cmp2_lo  = rd_acc & in_map & hit(a_idx, IDX_CMP2_LO);
  assign rd_cnt_lo   = rd_acc & in_map & hit(a_idx, IDX_CNT_LO);
  assign rd_alt_lo   = rd_acc & in_map & hit(a_idx, IDX_ALT_LO);

  // ==========================================================
  // Bus data phase
  logic        wr_q;
  logic [5:0]  widx_q;
  logic [31:0] rdata_q;
  logic [7:0]  rd_byte;
  logic        wr_ctrl;
  logic        wr_cnt;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_q   <= 1'b0;
      widx_q <= 6'h00;
    end else begin
      wr_q   <= acc & HWRITE & in_map;
      widx_q <= a_idx;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd_acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Writes to the flag register have no direct effect
  assign wr_ctrl   = wr_q & hit(widx_q, IDX_CTRL);
  assign wr_cnt    = wr_q & (hit(widx_q, IDX_CNT_LO) | hit(widx_q, IDX_ALT_LO));
  assign HRDATA    = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ==========================================================
  // Control register
  tfic_ctrl_t ctrl_q;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.cap_irq_en <= HWDATA[CTL_CAP_IE];
      ctrl_q.cmp_irq_en <= HWDATA[CTL_CMP_IE];
      ctrl_q.ovf_irq_en <= HWDATA[CTL_OVF_IE];
      ctrl_q.edge_sel   <= HWDATA[CTL_EDGE1];
    end
  end

  // ==========================================================
  // Prescaler and free-running counter
  logic [1:0]  pre_q;
  tfic_word_t  cnt_q;
  tfic_word_t  cnt_next;
  logic        tick;

  assign tick     = (pre_q == PRE_LAST);
  assign cnt_next = cnt_q + 16'h0001;

  // Counter low write restarts counter and prescaler
  always_ff @(posedge CORE_CLK) begin
    if (RST || wr_cnt) begin
      pre_q <= 2'h0;
      cnt_q <= CNT_RESET;
    end else begin
      pre_q <= pre_q + 2'h1;
      if (tick) begin
        cnt_q <= cnt_next;
      end
    end
  end

  assign COUNTER_VALUE = cnt_q;

  // ==========================================================
  // Event sources
  logic cmp1_set;
  logic cmp2_set;
  logic ovf_set;

  // A counter restart is not a count step, so it neither matches nor wraps
  assign cmp1_set = tick & ~wr_cnt & (cnt_next == COMPARE1_VALUE);
  assign cmp2_set = tick & ~wr_cnt & (cnt_next == COMPARE2_VALUE);
  assign ovf_set  = tick & ~wr_cnt & (cnt_q == CNT_MAX);

  // ==========================================================
  // Input capture channels
  logic [1:0]  pin_w;
  logic [1:0]  pin_q;
  logic        pin_ok_q;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  cap_evt;
  logic [1:0]  hi_rd;
  logic [1:0]  lo_rd;
  logic [1:0]  lock_q;
  logic [1:0]  load;
  tfic_word_t  cap_q [2];

  assign pin_w = {CAPTURE_IN2, CAPTURE_IN1};
  assign hi_rd = {rd_cap2_hi, rd_cap1_hi};
  assign lo_rd = {rd_cap2_lo, rd_cap1_lo};
  assign rise  = pin_w & ~pin_q & {2{pin_ok_q}};
  assign fall  = ~pin_w & pin_q & {2{pin_ok_q}};

  assign cap_evt[0] = ctrl_q.edge_sel ? rise[0] : fall[0];
  assign cap_evt[1] = fall[1];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_q    <= 2'h3;
      pin_ok_q <= 1'b0;
    end else begin
      pin_q    <= pin_w;
      pin_ok_q <= 1'b1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_cap
    // A low read in the transfer cycle still lets it through
    assign load[g] = cap_evt[g] & (~lock_q[g] | lo_rd[g]);

    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        lock_q[g] <= 1'b0;
      end else if (lo_rd[g]) begin
        lock_q[g] <= 1'b0;
      end else if (hi_rd[g]) begin
        lock_q[g] <= 1'b1;
      end
    end

    // No reset on the captured value
    always_ff @(posedge CORE_CLK) begin
      if (load[g]) begin
        cap_q[g] <= cnt_next;
      end
    end
  end

  // ==========================================================
  // Event flags with two-step clear
  logic [FLG_NUM-1:0] flags_q;
  logic [FLG_NUM-1:0] arm_q;
  logic [FLG_NUM-1:0] set_v;
  logic [FLG_NUM-1:0] arm_src;
  logic [FLG_NUM-1:0] fin_rd;

  assign set_v = {cap_evt[0], cmp1_set, ovf_set, cap_evt[1], cmp2_set};

  // Overflow arms on any flag access, the others on a read
  assign arm_src = {rd_flags, rd_flags, touch_flags, rd_flags, rd_flags};

  // Alternate counter low is absent here on purpose
  assign fin_rd = {rd_cap1_lo, rd_cmp1_lo, rd_cnt_lo, rd_cap2_lo, rd_cmp2_lo};

  for (genvar f = 0; f < FLG_NUM; f++) begin : g_flag
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        arm_q[f] <= 1'b0;
      end else if (arm_src[f] & flags_q[f]) begin
        arm_q[f] <= 1'b1;
      end else if (fin_rd[f]) begin
        arm_q[f] <= 1'b0;
      end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        flags_q[f] <= 1'b0;
      end else if (set_v[f]) begin
        flags_q[f] <= 1'b1;
      end else if (arm_q[f] & fin_rd[f]) begin
        flags_q[f] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt request
  logic cap_any;
  logic cmp_any;

  assign cap_any   = flags_q[FLG_CAP1] | flags_q[FLG_CAP2];
  assign cmp_any   = flags_q[FLG_CMP1] | flags_q[FLG_CMP2];
  assign TIMER_IRQ = (ctrl_q.cap_irq_en & cap_any) |
                     (ctrl_q.cmp_irq_en & cmp_any) |
                     (ctrl_q.ovf_irq_en & flags_q[FLG_OVF]);

  // ==========================================================
  // Read selection
  always_comb begin
    rd_byte = 8'h00;
    if (in_map) begin
      case (a_idx)
        IDX_CTRL:    rd_byte = {ctrl_q.cap_irq_en, ctrl_q.cmp_irq_en,
                                ctrl_q.ovf_irq_en, 3'h0, ctrl_q.edge_sel, 1'h0};
        IDX_FLAGS:   rd_byte = {flags_q, 3'h0};
        IDX_CAP1_HI: rd_byte = cap_q[0][15:8];
        IDX_CAP1_LO: rd_byte = cap_q[0][7:0];
        IDX_CMP1_HI: rd_byte = COMPARE1_VALUE[15:8];
        IDX_CMP1_LO: rd_byte = COMPARE1_VALUE[7:0];
        IDX_CNT_HI:  rd_byte = cnt_q[15:8];
        IDX_CNT_LO:  rd_byte = cnt_q[7:0];
        IDX_ALT_HI:  rd_byte = cnt_q[15:8];
        IDX_ALT_LO:  rd_byte = cnt_q[7:0];
        IDX_CAP2_HI: rd_byte = cap_q[1][15:8];
        IDX_CAP2_LO: rd_byte = cap_q[1][7:0];
        IDX_CMP2_HI: rd_byte = COMPARE2_VALUE[15:8];
        IDX_CMP2_LO: rd_byte = COMPARE2_VALUE[7:0];
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_cap1_clear;
    arm_q[FLG_CAP1] && rd_cap1_lo && !cap_evt[0];
  endsequence

  sequence s_tick_gap;
    !tick [*3];
  endsequence

  sequence s_ovf_clear;
    arm_q[FLG_OVF] && rd_cnt_lo && !ovf_set;
  endsequence

  a_flag_layout: assert property (
    rd_flags |=> (HRDATA[2:0] == 3'h0) && (HRDATA[7:3] == $past(flags_q)))
    else $error("flag register read layout wrong");

  a_cap1_clear: assert property (
    s_cap1_clear |=> !flags_q[FLG_CAP1])
    else $error("capture1 flag not cleared");

  a_ovf_wrap: assert property (
    ovf_set |=> flags_q[FLG_OVF] && (cnt_q == 16'h0000))
    else $error("overflow flag not set on wrap");

  a_alt_keeps_ovf: assert property (
    (flags_q[FLG_OVF] && rd_alt_lo) |=> flags_q[FLG_OVF])
    else $error("alternate read cleared overflow");

  a_cap_value: assert property (
    load[0] |=> cap_q[0] == $past(cnt_q) + 16'h0001)
    else $error("capture1 value not count plus one");

  a_lock_holds: assert property (
    (lock_q[1] && !rd_cap2_lo) |=> $stable(cap_q[1]))
    else $error("capture2 changed while locked");

  a_cap2_fall: assert property (
    (pin_ok_q && $fell(CAPTURE_IN2)) |=> flags_q[FLG_CAP2])
    else $error("capture2 flag missed falling edge");

  a_prescale: assert property (
    (tick && !wr_cnt) |=> s_tick_gap ##1
      (tick || $past(wr_cnt, 1) || $past(wr_cnt, 2) || $past(wr_cnt, 3)))
    else $error("prescaler period not four");

  a_ovf_arm: assert property (
    (acc && HWRITE && in_map && hit(a_idx, IDX_FLAGS) && flags_q[FLG_OVF]) |=> arm_q[FLG_OVF])
    else $error("flag write did not arm overflow");

  a_ovf_clear: assert property (
    s_ovf_clear |=> !flags_q[FLG_OVF])
    else $error("overflow flag not cleared by counter low read");

  a_cmp1_match: assert property (
    ($changed(cnt_q) && !$past(wr_cnt) && (cnt_q == $past(COMPARE1_VALUE)))
      |-> flags_q[FLG_CMP1])
    else $error("compare1 flag missed a match");

  a_cmp2_match: assert property (
    ($changed(cnt_q) && !$past(wr_cnt) && (cnt_q == $past(COMPARE2_VALUE)))
      |-> flags_q[FLG_CMP2])
    else $error("compare2 flag missed a match");

  a_cap2_value: assert property (
    load[1] |=> cap_q[1] == $past(cnt_q) + 16'h0001)
    else $error("capture2 value not count plus one");

  a_flag_write: assert property (
    (wr_q && hit(widx_q, IDX_FLAGS) && !(|set_v) && !(|fin_rd)) |=> $stable(flags_q))
    else $error("flag register write changed a flag");
endmodule
`default_nettype wire

// ==== verification/tfic_pin_model.sv ====
/*
  Model of the external signal sources on the two capture pins.
  Assumes the bench calls set_pin once per level change, one cycle apart at least.
*/
`timescale 1ns/1ps
`default_nettype none
module tfic_pin_model (
  input  wire logic clk,
  output var logic  pin1,
  output var logic  pin2
);
  // ==========================================================
  // Idle levels, then a level change just after a rising edge
  initial begin
    pin1 = 1'b0;
    pin2 = 1'b1;
  end
  task automatic set_pin(input bit ch, input logic lvl);
    @(posedge clk);
    if (ch) pin2 <= lvl;
    else pin1 <= lvl;
  endtask
endmodule
`default_nettype wire

// ==== verification/timer_flags_input_capture_test.sv ====
/*
  Self-checking bench for the timer flags and input capture block.
  Assumes a single AHB-Lite slave whose HREADYOUT is the bus HREADY.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_flags_input_capture_test;
  import tfic_pkg::*;
  logic        clk, rst, hsel, hwrite, pin1, pin2, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  tfic_word_t  cmp1, cmp2, cnt, c;
  int          error_cnt, total_checks;

  tfic_timer_flags dut (.CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CAPTURE_IN1(pin1), .CAPTURE_IN2(pin2), .COMPARE1_VALUE(cmp1),
    .COMPARE2_VALUE(cmp2), .COUNTER_VALUE(cnt), .TIMER_IRQ(irq));
  tfic_pin_model src (.clk(clk), .pin1(pin1), .pin2(pin2));

  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic edge_at(input bit ch, input logic lvl);
    src.set_pin(ch, lvl);
    #1 c = cnt + 16'h1;
  endtask
  task automatic capt(input bit ch, input logic [7:0] fl);
    logic [5:0] hi;
    hi = ch ? IDX_CAP2_HI : IDX_CAP1_HI;
    rdc(IDX_FLAGS, fl);
    rdc(hi, c[15:8]);
    rdc(hi + 6'h1, c[7:0]);
    rdc(IDX_FLAGS, 8'h00);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_count;
    rdc(IDX_FLAGS, 8'h00);
    rdc(6'h05, 8'h00);
    chk({hreadyout, hresp}, 32'h2);
    @(posedge clk) #1 c = cnt;
    repeat (8) @(posedge clk);
    #1 chk(cnt, c + 16'h2);
    bus(1'b1, IDX_CNT_LO, 8'h00);
    #1 chk(cnt, CNT_RESET);
    rdc(IDX_CNT_HI, 8'hFF);
  endtask
  task automatic t_ovf;
    bus(1'b1, IDX_CTRL, 8'h20);
    repeat (20) @(posedge clk);
    #1 chk(irq, 1'b1);
    bus(1'b1, IDX_FLAGS, 8'hFF);
    bus(1'b0, IDX_ALT_LO, 8'h00);
    #1 chk(irq, 1'b1);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    #1 chk(irq, 1'b0);
  endtask
  task automatic t_cmp(input bit ch);
    bus(1'b1, IDX_CTRL, 8'h40);
    @(posedge clk);
    if (ch) cmp2 <= cnt + 16'h3;
    else cmp1 <= cnt + 16'h3;
    repeat (16) @(posedge clk);
    #1 chk(irq, 1'b1);
    rdc(IDX_FLAGS, ch ? 8'h08 : 8'h40);
    rdc(ch ? IDX_CMP2_HI : IDX_CMP1_HI, ch ? cmp2[15:8] : cmp1[15:8]);
    bus(1'b0, ch ? IDX_CMP2_LO : IDX_CMP1_LO, 8'h00);
    rdc(IDX_FLAGS, 8'h00);
  endtask
  task automatic t_cap1;
    bus(1'b1, IDX_CTRL, 8'h82);
    rdc(IDX_CTRL, 8'h82);
    edge_at(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    capt(1'b0, 8'h80);
    edge_at(1'b0, 1'b0);
    rdc(IDX_FLAGS, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h00);
    edge_at(1'b0, 1'b1);
    edge_at(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    capt(1'b0, 8'h80);
  endtask
  task automatic t_cap2;
    edge_at(1'b1, 1'b0);
    capt(1'b1, 8'h10);
    edge_at(1'b1, 1'b1);
    rdc(IDX_FLAGS, 8'h00);
    edge_at(1'b1, 1'b0);
    rdc(IDX_FLAGS, 8'h10);
    rdc(IDX_CAP2_HI, c[15:8]);
    src.set_pin(1'b1, 1'b1);
    src.set_pin(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    rdc(IDX_CAP2_LO, c[7:0]);
    edge_at(1'b1, 1'b1);
    edge_at(1'b1, 1'b0);
    edge_at(1'b1, 1'b1);
    edge_at(1'b1, 1'b0);
    capt(1'b1, 8'h10);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_CAP2_HI, c[15:8]);
    rdc(IDX_CAP2_LO, c[7:0]);
  endtask

  // ==========================================================
  // Clock, sequence, watchdog and verdict
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    cmp1 = 16'h8000;
    cmp2 = 16'h8000;
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_count();
    t_ovf();
    t_cmp(1'b0);
    t_cmp(1'b1);
    t_cap1();
    t_cap2();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
